// ---- cp_seq_params.svh ----
// Timing counts, sink count and field positions for the charge pump sequencer
`ifndef CP_SEQ_PARAMS_SVH
`define CP_SEQ_PARAMS_SVH
`define CP_CLK_HZ 40000000
`define CP_SETTLE_US 100
`define CP_SETTLE_CYCLES ((`CP_SETTLE_US * `CP_CLK_HZ) / 1000000)
`define CP_RST_FILTER_US 50
`define CP_RST_FILTER_CYCLES ((`CP_RST_FILTER_US * `CP_CLK_HZ) / 1000000)
`define CP_OSC_DIV 40
`define CP_NONOVL_CYCLES 2
`define CP_SINKS 7
`define CP_MODE_STBY_REL_BIT 0
`define CP_MODE_RESET 8'h00
`define CP_SINK_EN_RESET 7'h00
`define CP_SW_PASS 0
`define CP_SW_SERIES 1
`define CP_SW_PAR_CHG 2
`define CP_SW_PAR_DIS 3
`define CP_SW_SOFT 4
`define CP_SW_WIDTH 5
`endif

// ---- cp_seq_pkg.sv ----
// Types shared by the charge pump sequencer files
package cp_seq_pkg;
	typedef enum logic [1:0] {GAIN_1X, GAIN_1P5X, GAIN_2X, GAIN_OFF} gain_type;
	typedef enum logic [1:0] {MODE_SHUTDOWN, MODE_STANDBY, MODE_SOFTSTART, MODE_ACTIVE} opmode_type;
endpackage

// ---- cp_sync2.sv ----
// Two flip-flop synchroniser for a bus of comparator levels
`timescale 1ns/1ps
module cp_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic sysClk,
	input wire logic rstN,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge sysClk or negedge rstN) begin
		if (!rstN) begin
			meta_q <= '0;
			syncOut <= '0;
		end else begin
			meta_q <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule

// ---- cp_switch_seq.sv ----
// Pump switch sequencer: bypass, series/parallel phases and isolation
`timescale 1ns/1ps
`include "cp_seq_params.svh"
module cp_switch_seq #(
	parameter int OSC_DIV = `CP_OSC_DIV,
	parameter int NONOVL = `CP_NONOVL_CYCLES
) (
	input wire logic sysClk,
	input wire logic rstN,
	input wire cp_seq_pkg::gain_type gain,
	input wire logic softStart,
	output logic [`CP_SW_WIDTH-1:0] switchCtl
);
	import cp_seq_pkg::*;

	typedef enum logic [1:0] {PH_CHARGE, PH_GAP1, PH_DISCH, PH_GAP2} phase_type;
	phase_type phase_q;
	logic [7:0] div_q;
	logic tick;
	logic [`CP_SW_WIDTH-1:0] sw_d;

	// Oscillator divider gives one enable pulse per phase slot
	always_ff @(posedge sysClk or negedge rstN) begin
		if (!rstN) begin
			div_q <= 8'h00;
		end else if (tick) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	// Gap phases are short so non-overlap costs little charge time
	assign tick = (phase_q == PH_GAP1 || phase_q == PH_GAP2) ?
		(div_q == 8'(NONOVL - 1)) : (div_q == 8'(OSC_DIV - 1));

	always_ff @(posedge sysClk or negedge rstN) begin
		if (!rstN) begin
			phase_q <= PH_CHARGE;
		end else if (tick) begin
			phase_q <= phase_type'(phase_q + 2'd1);
		end
	end

	// Switch pattern decode per gain and phase
	always_comb begin
		sw_d = '0;
		unique case (gain)
			GAIN_1X: begin
				sw_d[`CP_SW_PASS] = 1'b1;
			end
			GAIN_1P5X: begin
				if (phase_q == PH_CHARGE) begin
					sw_d[`CP_SW_SERIES] = 1'b1;
				end else if (phase_q == PH_DISCH) begin
					sw_d[`CP_SW_PAR_DIS] = 1'b1;
				end
			end
			GAIN_2X: begin
				if (phase_q == PH_CHARGE) begin
					sw_d[`CP_SW_PAR_CHG] = 1'b1;
				end else if (phase_q == PH_DISCH) begin
					sw_d[`CP_SW_PAR_DIS] = 1'b1;
				end
			end
			GAIN_OFF: begin
				sw_d = '0;
			end
		endcase
		if (softStart) begin
			sw_d = '0;
			sw_d[`CP_SW_SOFT] = 1'b1;
		end
	end

	// Registered switch drive
	always_ff @(posedge sysClk or negedge rstN) begin
		if (!rstN) begin
			switchCtl <= '0;
		end else begin
			switchCtl <= sw_d;
		end
	end
endmodule

// ---- charge_pump_gain_mode_sequencer.sv ----
// Mode sequencer and automatic gain selection for the LED charge pump
// Operation
// - After soft start the pump begins in unity gain.
// - Any enabled sink below headroom raises gain one step.
// - Wait 100 us after each gain change before deciding again.
// - All enabled sinks above upper threshold lower gain one step.
// - Disabled sinks are masked out of gain decisions.
// - Soft start current path until output reaches 92% of input.
// - Soft start after undervoltage release, fault recovery or standby exit.
// - Standby-release bit set to one enters active mode.
// - Standby when release bit is zero or reset pin held low.
// - Standby disables everything but the serial-bus receivers.
// - Below undervoltage threshold the device is shut down entirely.
// - Supply above start threshold resets registers and enters standby.
// - Isolating faults open all pump switches.
// - 1.5x charges series, discharges parallel; 2x parallel both.
// - Unity gain closes bypass switches continuously.
// - Reset pin low holds standby, defaults, and no bus acknowledge.
// - Reset pin is filtered about 50 us before acting.
`timescale 1ns/1ps
`include "cp_seq_params.svh"
module charge_pump_gain_mode_sequencer #(
	parameter int SINKS = `CP_SINKS,
	parameter int SETTLE_CYCLES = `CP_SETTLE_CYCLES,
	parameter int RST_FILTER_CYCLES = `CP_RST_FILTER_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic supplyAboveStart,
	input wire logic hwResetLowPin_n,
	input wire logic faultIsolate,
	input wire logic faultRecover,
	input wire logic modeWrite,
	input wire logic [7:0] modeWriteData,
	input wire logic sinkEnWrite,
	input wire logic [SINKS-1:0] sinkEnWriteData,
	input wire logic [SINKS-1:0] sinkBelowHeadroom,
	input wire logic [SINKS-1:0] sinkAboveUpper,
	input wire logic outputAtSoftTarget,
	output logic [7:0] modeControlRegister,
	output logic [SINKS-1:0] sinkEnable,
	output cp_seq_pkg::gain_type gain,
	output cp_seq_pkg::opmode_type opMode,
	output logic [`CP_SW_WIDTH-1:0] switchCtl,
	output logic busReceiverEn,
	output logic busAckEn,
	output logic circuitsEn
);
	import cp_seq_pkg::*;

	logic rstS1_q;
	logic rstN;
	logic [SINKS-1:0] belowSync;
	logic [SINKS-1:0] aboveSync;
	logic softDoneSync;
	logic pinSync;
	logic pinLow;
	logic [15:0] filt_q;
	logic pinReset_q;
	logic regClear;
	logic standbyRel;
	logic [15:0] settle_q;
	logic settled;
	logic anyLow;
	logic allHigh;
	logic [SINKS-1:0] lowMask;
	logic [SINKS-1:0] highMask;
	logic dropStandby;
	logic isolate;
	logic softStart;
	gain_type gain_d;
	opmode_type mode_d;

	// One step up the gain ladder; 2x is the ceiling
	function automatic gain_type stepUp(input gain_type g);
		gain_type r;
		r = g;
		if (g == GAIN_1X) begin
			r = GAIN_1P5X;
		end else if (g == GAIN_1P5X) begin
			r = GAIN_2X;
		end
		return r;
	endfunction

	// One step down the gain ladder; unity is the floor
	function automatic gain_type stepDown(input gain_type g);
		gain_type r;
		r = g;
		if (g == GAIN_2X) begin
			r = GAIN_1P5X;
		end else if (g == GAIN_1P5X) begin
			r = GAIN_1X;
		end
		return r;
	endfunction

	// Reset release through two flip-flops
	// Assertion is immediate; release waits two edges so no flop sees a runt
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstS1_q <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstS1_q <= 1'b1;
			rstN <= rstS1_q;
		end
	end

	cp_sync2 #(.WIDTH(2 * SINKS + 1)) compSync (
		.sysClk(sys_clk),
		.rstN(rstN),
		.asyncIn({sinkBelowHeadroom, sinkAboveUpper, outputAtSoftTarget}),
		.syncOut({belowSync, aboveSync, softDoneSync})
	);

	// Reset pin sampled once through one flop; its reset is asynchronous and loads the idle high level
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			pinSync <= 1'b1;
		end else begin
			pinSync <= hwResetLowPin_n;
		end
	end
	assign pinLow = !pinSync;

	// A short dip restarts the count, so line noise never clears the registers
	// low level must persist for the filter time
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			filt_q <= 16'h0000;
			pinReset_q <= 1'b0;
		end else if (!pinLow) begin
			filt_q <= 16'h0000;
			pinReset_q <= 1'b0;
		end else if (filt_q == 16'(RST_FILTER_CYCLES - 1)) begin
			pinReset_q <= 1'b1;
		end else begin
			filt_q <= filt_q + 16'h0001;
		end
	end

	// Clearing is a level, so registers stay at default while it lasts
	// registers return to defaults in shutdown and pin reset
	assign regClear = !supplyAboveStart || pinReset_q;

	// Mode control register, host written
	// A clear wins over a write that lands in the same cycle
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			modeControlRegister <= `CP_MODE_RESET;
		end else if (regClear) begin
			modeControlRegister <= `CP_MODE_RESET;
		end else if (modeWrite) begin
			modeControlRegister <= modeWriteData;
		end
	end

	// Cleared with the mode register, so a reset leaves every sink out
	// host sink enables
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			sinkEnable <= `CP_SINK_EN_RESET;
		end else if (regClear) begin
			sinkEnable <= `CP_SINK_EN_RESET;
		end else if (sinkEnWrite) begin
			sinkEnable <= sinkEnWriteData;
		end
	end

	assign standbyRel = modeControlRegister[`CP_MODE_STBY_REL_BIT];

	// release bit low or filtered pin reset sends the pump to standby
	assign dropStandby = !standbyRel || pinReset_q;

	// Operating mode sequencing
	// Undervoltage overrides every state, so no state needs its own shutdown arm
	always_comb begin
		mode_d = opMode;
		if (!supplyAboveStart) begin
			mode_d = MODE_SHUTDOWN;
		end else begin
			unique case (opMode)
				MODE_SHUTDOWN: begin
					mode_d = MODE_STANDBY;
				end
				MODE_STANDBY: begin
					// release bit enters active via soft start
					if (standbyRel && !pinReset_q) begin
						mode_d = MODE_SOFTSTART;
					end
				end
				MODE_SOFTSTART: begin
					// standby on release bit low or pin reset
					if (dropStandby) begin
						mode_d = MODE_STANDBY;
					end else if (faultIsolate) begin
						mode_d = MODE_SOFTSTART;
					end else if (softDoneSync) begin
						// soft start ends at output target
						mode_d = MODE_ACTIVE;
					end
				end
				MODE_ACTIVE: begin
					// standby on release bit low or pin reset
					if (dropStandby) begin
						mode_d = MODE_STANDBY;
					end else if (faultIsolate) begin
						// restart through soft start after fault
						mode_d = MODE_SOFTSTART;
					end
				end
			endcase
		end
	end

	// Shutdown is the reset state; the first edge after release moves on
	// Mode register; faults hold soft start while faultIsolate stays high; faultRecover does not affect the mode
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			opMode <= MODE_SHUTDOWN;
		end else begin
			opMode <= mode_d;
		end
	end

	// standby keeps only bus receivers alive
	assign circuitsEn = (opMode == MODE_SOFTSTART) || (opMode == MODE_ACTIVE);
	assign busReceiverEn = (opMode != MODE_SHUTDOWN);
	// The once-sampled pin gates it too, so the bus goes quiet before the filter ends
	// no acknowledge while the pin reset holds
	assign busAckEn = busReceiverEn && !pinReset_q && !pinLow;

	// per-sink masking of the synchronised comparators
	for (genvar s = 0; s < SINKS; s++) begin : g_mask
		assign lowMask[s] = belowSync[s] && sinkEnable[s];
		assign highMask[s] = aboveSync[s] || !sinkEnable[s];
	end

	// Summaries; with no sink enabled nothing asks for a step either way
	assign anyLow = |lowMask;
	assign allHigh = (sinkEnable != '0) && (&highMask);

	// A change to isolation reloads it as well, so restarts also wait
	// settle timer restarted by every gain change
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			settle_q <= 16'h0000;
		end else if (gain_d != gain) begin
			settle_q <= 16'(SETTLE_CYCLES);
		end else if (settle_q != 16'h0000) begin
			settle_q <= settle_q - 16'h0001;
		end
	end
	assign settled = (settle_q == 16'h0000);

	// isolation whenever the pump is not in active operation
	assign isolate = (opMode != MODE_ACTIVE) || faultIsolate;

	// Gain decision; raising wins over lowering so a starved sink is served first
	always_comb begin
		gain_d = gain;
		if (isolate) begin
			gain_d = GAIN_OFF;
		end else if (gain == GAIN_OFF) begin
			// start in unity after soft start
			gain_d = GAIN_1X;
		end else if (settled) begin
			if (anyLow) begin
				gain_d = stepUp(gain);
			end else if (allHigh) begin
				gain_d = stepDown(gain);
			end
		end
	end

	// Gain register
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			gain <= GAIN_OFF;
		end else begin
			gain <= gain_d;
		end
	end

	// Soft start path active only while charging and no fault isolates
	// Recovery keeps it open so a fault cannot restart the inrush at once
	assign softStart = (opMode == MODE_SOFTSTART) && !faultIsolate && !faultRecover;

	// Switch network driver; it owns the phase oscillator
	cp_switch_seq switchSeq (
		.sysClk(sys_clk),
		.rstN(rstN),
		.gain(gain),
		.softStart(softStart),
		.switchCtl(switchCtl)
	);
endmodule

// ---- cp_seq_chk.sv ----
// Concurrent checks on the charge pump sequencer top ports
`timescale 1ns/1ps
`include "cp_seq_params.svh"
module cp_seq_chk
import cp_seq_pkg::*;
#(
	parameter int SINKS = 7,
	parameter int SETTLE_CYCLES = 20,
	parameter int RST_FILTER_CYCLES = 10
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic supplyAboveStart,
	input wire logic hwResetLowPin_n,
	input wire logic faultIsolate,
	input wire logic faultRecover,
	input wire logic [7:0] modeControlRegister,
	input wire logic [SINKS-1:0] sinkEnable,
	input wire cp_seq_pkg::gain_type gain,
	input wire cp_seq_pkg::opmode_type opMode,
	input wire logic [`CP_SW_WIDTH-1:0] switchCtl,
	input wire logic busReceiverEn,
	input wire logic busAckEn,
	input wire logic circuitsEn
);
	gain_type gainPrev_q;
	int gap_q;
	int pinLow_q;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// Cycles since the last gain change, saturating so the count never wraps
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			gainPrev_q <= GAIN_OFF;
			gap_q <= 0;
		end else begin
			gainPrev_q <= gain;
			if (gain != gainPrev_q)
				gap_q <= 1;
			else if (gap_q < SETTLE_CYCLES)
				gap_q <= gap_q + 1;
		end
	end
	// Length of the current low run on the reset pin
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pinLow_q <= 0;
		end else if (hwResetLowPin_n) begin
			pinLow_q <= 0;
		end else if (pinLow_q < 255) begin
			pinLow_q <= pinLow_q + 1;
		end
	end
	sequence softDone;
		opMode == MODE_SOFTSTART ##1 opMode == MODE_ACTIVE;
	endsequence
	sequence releaseSet;
		$rose(modeControlRegister[0]) && supplyAboveStart && hwResetLowPin_n && !faultIsolate;
	endsequence
	sequence stepSeen;
		gain != gainPrev_q && gain != GAIN_OFF && gainPrev_q != GAIN_OFF;
	endsequence
	a_bus_enables: assert property (
		busReceiverEn == (opMode != MODE_SHUTDOWN) && circuitsEn == (opMode >= MODE_SOFTSTART))
		else $error("Enable outputs disagree with mode");
	a_release_start: assert property (releaseSet |-> ##[0:2] opMode == MODE_SOFTSTART)
		else $error("Standby release did not start soft start");
	a_start_unity: assert property (softDone |=> gain == GAIN_1X)
		else $error("Active mode did not begin in unity gain");
	a_isolate_open: assert property (faultIsolate [*3] |-> switchCtl == '0 && gain == GAIN_OFF)
		else $error("Pump switches not open during fault");
	a_unity_bypass: assert property (
		(gain == GAIN_1X && opMode == MODE_ACTIVE) [*4] |-> switchCtl == 5'h01)
		else $error("Unity gain without steady bypass");
	a_no_overlap: assert property (
		!(|switchCtl[2:1] && switchCtl[3]) && !(switchCtl[0] && |switchCtl[3:1]))
		else $error("Switch sets closed together");
	a_phase_gap: assert property ($fell(switchCtl[3]) |=> !(|switchCtl[2:1]))
		else $error("No gap after discharge phase");
	a_step_one: assert property (
		stepSeen |-> 2'(gain - gainPrev_q) == 2'h1 || 2'(gainPrev_q - gain) == 2'h1)
		else $error("Gain moved more than one step");
	a_settle_wait: assert property (stepSeen |-> gap_q >= SETTLE_CYCLES)
		else $error("Gain changed before settle time");
	a_soft_path: assert property (
		(opMode == MODE_SOFTSTART && !faultIsolate && !faultRecover) [*3] |-> switchCtl[4]
		&& !switchCtl[0])
		else $error("Soft start path not closed");
	a_pin_reset: assert property (
		pinLow_q > RST_FILTER_CYCLES + 3 && supplyAboveStart |-> opMode == MODE_STANDBY
		&& modeControlRegister == 8'h00 && sinkEnable == '0 && !busAckEn)
		else $error("Held reset pin did not force standby");
	a_shutdown: assert property (
		!supplyAboveStart [*3] |-> opMode == MODE_SHUTDOWN && modeControlRegister == 8'h00)
		else $error("Low supply did not shut down");
endmodule
bind charge_pump_gain_mode_sequencer cp_seq_chk #(
	.SINKS(SINKS),
	.SETTLE_CYCLES(SETTLE_CYCLES),
	.RST_FILTER_CYCLES(RST_FILTER_CYCLES)
) i_chk (
	.sys_clk(sys_clk), .rst_b(rst_b), .supplyAboveStart(supplyAboveStart),
	.hwResetLowPin_n(hwResetLowPin_n), .faultIsolate(faultIsolate),
	.faultRecover(faultRecover), .modeControlRegister(modeControlRegister),
	.sinkEnable(sinkEnable), .gain(gain), .opMode(opMode), .switchCtl(switchCtl),
	.busReceiverEn(busReceiverEn), .busAckEn(busAckEn), .circuitsEn(circuitsEn)
);

// ---- cp_analog_model.sv ----
// Analog side model: sink headroom comparators and soft-start output level
`timescale 1ns/1ps
`include "cp_seq_params.svh"
module cp_analog_model
import cp_seq_pkg::*;
(
	input wire logic sysClk,
	input wire cp_seq_pkg::gain_type gain,
	input wire logic [`CP_SW_WIDTH-1:0] switchCtl,
	input wire logic [6:0] loadMask,
	input wire logic [1:0] needGain,
	output logic [6:0] below,
	output logic [6:0] above,
	output logic softTarget
);
	logic [3:0] charge_q;
	// Loaded sinks starve below the needed gain; idle sinks always have spare headroom
	assign below = (2'(gain) < needGain) ? loadMask : 7'h00;
	assign above = ~loadMask | ((gain != GAIN_OFF && 2'(gain) > needGain) ? 7'h7F : 7'h00);
	// Output climbs only through the soft path and collapses once the pump is open
	always_ff @(posedge sysClk) begin
		if (switchCtl == '0)
			charge_q <= 4'h0;
		else if (switchCtl[`CP_SW_SOFT] && charge_q != 4'hF)
			charge_q <= charge_q + 4'h1;
	end
	assign softTarget = (charge_q == 4'hF);
endmodule

// ---- tb.sv ----
// Self-checking bench for the charge pump gain and mode sequencer
`timescale 1ns/1ps
`include "cp_seq_params.svh"
module tb;
	import cp_seq_pkg::*;
	localparam int ST = 20;
	localparam int RF = 10;
	typedef struct packed {
		logic [6:0] en;
		logic [6:0] load;
		logic [1:0] need;
		logic [1:0] g;
	} row_type;
	// Sink enables, loaded sinks and needed gain beside the gain they settle to
	row_type rows [5] = '{'{7'h7F, 7'h01, 2'h0, 2'h0}, '{7'h7E, 7'h01, 2'h2, 2'h0},
		'{7'h7F, 7'h01, 2'h2, 2'h2}, '{7'h7F, 7'h01, 2'h1, 2'h1}, '{7'h7E, 7'h01, 2'h2, 2'h0}};
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic supplyAboveStart = 1'b1;
	logic hwResetLowPin_n = 1'b1;
	logic faultIsolate = 1'b0;
	logic faultRecover = 1'b0;
	logic modeWrite = 1'b0;
	logic sinkEnWrite = 1'b0;
	logic [7:0] wrData = 8'h00;
	logic [6:0] loadMask = 7'h00;
	logic [1:0] needGain = 2'h0;
	logic [6:0] below, above, sinkEnable;
	logic softTarget, busReceiverEn, busAckEn, circuitsEn;
	logic [7:0] mcr;
	gain_type gain;
	opmode_type opMode;
	logic [`CP_SW_WIDTH-1:0] switchCtl;
	int errTotal = 0;
	int nTests = 0;
	// 40 MHz system clock
	always #12.5 sys_clk = ~sys_clk;
	charge_pump_gain_mode_sequencer #(.SETTLE_CYCLES(ST), .RST_FILTER_CYCLES(RF)) i_dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .supplyAboveStart(supplyAboveStart),
		.hwResetLowPin_n(hwResetLowPin_n), .faultIsolate(faultIsolate),
		.faultRecover(faultRecover), .modeWrite(modeWrite), .modeWriteData(wrData),
		.sinkEnWrite(sinkEnWrite), .sinkEnWriteData(wrData[6:0]), .sinkBelowHeadroom(below),
		.sinkAboveUpper(above), .outputAtSoftTarget(softTarget), .modeControlRegister(mcr),
		.sinkEnable(sinkEnable), .gain(gain), .opMode(opMode), .switchCtl(switchCtl),
		.busReceiverEn(busReceiverEn), .busAckEn(busAckEn), .circuitsEn(circuitsEn));
	cp_analog_model i_pump (.sysClk(sys_clk), .gain(gain), .switchCtl(switchCtl),
		.loadMask(loadMask), .needGain(needGain), .below(below), .above(above),
		.softTarget(softTarget));
	// Report counts and the verdict, then stop
	task automatic conclude();
		$display("Checks %0d mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cmpV(input string nm, input logic [7:0] e, input logic [7:0] g);
		nTests++;
		if (g !== e) begin
			errTotal++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmpS(input string nm, input logic [1:0] e, input logic [1:0] g);
		cmpV(nm, {6'h00, e}, {6'h00, g});
	endtask
	// Sampling waits a little past the edge so registered outputs have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic m, input logic [7:0] d);
		@(posedge sys_clk);
		modeWrite <= m;
		sinkEnWrite <= !m;
		wrData <= d;
		@(posedge sys_clk);
		modeWrite <= 1'b0;
		sinkEnWrite <= 1'b0;
		#1;
	endtask
	// Bounded wait for gain (sel high) or mode to reach a value
	task automatic waitS(input logic sel, input logic [1:0] e);
		int i;
		for (i = 0; i < 3000; i++) begin
			if ((sel ? 2'(gain) : 2'(opMode)) === e)
				break;
			cyc(1);
		end
		if (i == 3000) begin
			errTotal++;
			$display("[ERR] state wait expected %h seen none", e);
			conclude();
		end
	endtask
	initial begin
		cyc(10);
		cmpS("gain", GAIN_OFF, gain);
		cmpS("mode", MODE_SHUTDOWN, opMode);
		cyc(9);
		@(posedge sys_clk);
		rst_b <= 1'b1;
		waitS(0, MODE_STANDBY);
		cmpV("mcr", 8'h00, mcr);
		cmpV("enables", 8'h02, {6'h00, busReceiverEn, circuitsEn});
		wr(1, 8'h01);
		waitS(0, MODE_ACTIVE);
		// Gain leaves isolation one edge after the mode turns active
		cyc(1);
		cmpS("gain", GAIN_1X, gain);
		cyc(4);
		cmpV("switches", 8'h01, {3'h0, switchCtl});
		// Table of sink settings, each held long enough for several decisions
		foreach (rows[r]) begin
			wr(0, {1'b0, rows[r].en});
			@(posedge sys_clk);
			loadMask <= rows[r].load;
			needGain <= rows[r].need;
			waitS(1, rows[r].g);
			cyc(3 * ST + 100);
			cmpS("gain", rows[r].g, gain);
		end
		@(posedge sys_clk);
		faultIsolate <= 1'b1;
		faultRecover <= 1'b1;
		cyc(5);
		cmpV("switches", 8'h00, {3'h0, switchCtl});
		cmpS("gain", GAIN_OFF, gain);
		@(posedge sys_clk);
		faultIsolate <= 1'b0;
		cyc(6);
		cmpV("softpath", 8'h00, {7'h00, switchCtl[4]});
		@(posedge sys_clk);
		faultRecover <= 1'b0;
		waitS(0, MODE_ACTIVE);
		wr(1, 8'h00);
		waitS(0, MODE_STANDBY);
		cmpV("enables", 8'h02, {6'h00, busReceiverEn, circuitsEn});
		wr(1, 8'h01);
		waitS(0, MODE_ACTIVE);
		// A glitch shorter than the filter must leave the registers alone
		@(posedge sys_clk);
		hwResetLowPin_n <= 1'b0;
		cyc(RF - 3);
		@(posedge sys_clk);
		hwResetLowPin_n <= 1'b1;
		cyc(5);
		cmpV("mcr", 8'h01, mcr);
		@(posedge sys_clk);
		hwResetLowPin_n <= 1'b0;
		cyc(RF + 6);
		wr(1, 8'h01);
		cmpV("mcr", 8'h00, mcr);
		cmpS("mode", MODE_STANDBY, opMode);
		cmpV("ack", 8'h00, {7'h00, busAckEn});
		@(posedge sys_clk);
		hwResetLowPin_n <= 1'b1;
		cyc(5);
		cmpV("ack", 8'h01, {7'h00, busAckEn});
		wr(0, 8'h7F);
		cmpV("sinkEnable", 8'h7F, {1'b0, sinkEnable});
		@(posedge sys_clk);
		supplyAboveStart <= 1'b0;
		wr(0, 8'h3F);
		cyc(3);
		cmpS("mode", MODE_SHUTDOWN, opMode);
		cmpV("enables", 8'h00, {6'h00, busReceiverEn, circuitsEn});
		@(posedge sys_clk);
		supplyAboveStart <= 1'b1;
		waitS(0, MODE_STANDBY);
		cmpV("sinkEnable", 8'h00, {1'b0, sinkEnable});
		conclude();
	end
endmodule
